// ---- src/ddt_pkg.sv ----
// Shared constants, field layouts and types of the DDR4 timing block
package ddt_pkg;

  // ****************************************
  // Clock and time conversion
  // ****************************************
  localparam int CLK_PERIOD_PS = 25000;
  localparam int PS_PER_NS = 1000;

  // Round a least time in ns up to whole cycles, never below one
  function automatic int ns_to_cyc_up(input int ns);
    int cyc;
    cyc = (ns * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (cyc < 1) ? 1 : cyc;
  endfunction

  // ****************************************
  // Timing figures
  // ****************************************
  localparam int CRC_ALERT_LAT_MIN_NS = 3;
  localparam int CRC_ALERT_LAT_MAX_NS = 13;
  localparam int CRC_ALERT_LAT_CYC = ns_to_cyc_up(CRC_ALERT_LAT_MIN_NS);
  localparam int CRC_ALERT_PULSE_WIDTH_MIN_NCK = 6;
  localparam int CRC_ALERT_PULSE_WIDTH_MAX_NCK = 10;
  localparam int CRC_ALERT_PULSE_WIDTH_NCK = 8;
  localparam int RFC1_NS = 260;
  localparam int RFC2_NS = 160;
  localparam int RFC4_NS = 110;
  localparam int RFC1_CYC = ns_to_cyc_up(RFC1_NS);
  localparam int RFC2_CYC = ns_to_cyc_up(RFC2_NS);
  localparam int RFC4_CYC = ns_to_cyc_up(RFC4_NS);
  localparam int WR_START_BL8_NCK = 4;
  localparam int WR_START_BC4_FIXED_NCK = 2;
  localparam int CNT_W = 8;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] MASK_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] STATE_ADDR = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0900;
  localparam int EVT_W = 4;
  localparam int EVT_CRC_ERR = 0;
  localparam int EVT_RFC_VIOL = 1;
  localparam int EVT_DLL_VIOL = 2;
  localparam int EVT_PD_ENTER = 3;
  localparam int STATE_RFC_BUSY = 0;
  localparam int STATE_PD_PEND = 1;
  localparam int STATE_PD_ASLEEP = 2;
  localparam int STATE_ALERT = 3;
  localparam int STATE_WR_PEND = 4;
  localparam int STATE_DLL_LOCK = 5;

  typedef enum logic [1:0] {FGR_1X = 2'h0, FGR_2X = 2'h1, FGR_4X = 2'h2} ddt_fgr_e;

  typedef struct packed {
    logic [18:0] rsvd_hi;
    logic [4:0] write_latency;
    logic [2:0] rsvd_lo;
    logic dm_en;
    logic crc_en;
    logic bc4_fixed;
    ddt_fgr_e fgr_mode;
  } ddt_ctrl_s;

  typedef struct packed {
    logic act;
    logic pre;
    logic ref_cmd;
    logic wr;
    logic rd;
    logic odt_sync;
  } ddt_cmd_s;

endpackage

// ---- src/ddt_timing.sv ----
// DDR4 device-side CRC alert, refresh, write start and power-down timing
//
// Rules for this block and the controller driving it
// [R1] Alert asserts 3 to 13 ns after CRC error; here it asserts one clock after the edge that samples the error
// [R2] Alert pulse lasts 6 to 10 clocks
// [R3] Controller waits refresh period before activate/refresh
// [R4] Refresh period follows fine-granularity refresh mode
// [R5] Internal write starts WL+4, or WL+2 fixed chop
// [R6] Controller rounds recovery time up to clocks
// [R7] Power-down wait is WL+4+recovery clocks
// [R8] CRC with mask uses longer recovery variants
// [R9] Reads and synchronous termination need locked loop
// [R10] Pending operations finish before power-down state
// [R11] Nanosecond parameters round up to whole clocks
// [R12] Refresh interval bounds the slowest clock
`timescale 1ns/10ps

module ddt_timing #(
  parameter int WL_MAX = 31,
  parameter int ROW_OP_CYC = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [ddt_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Memory command side
  input wire ddt_pkg::ddt_cmd_s cmd_i,
  input wire logic cke_i,
  input wire logic dll_locked_i,
  input wire logic crc_err_i,
  // Device outputs
  output logic alert_n_o,
  output logic wr_start_o,
  output logic refresh_busy_o,
  output logic powerdown_o,
  output logic irq_o
);

  localparam int PIPE_LEN = WL_MAX + ddt_pkg::WR_START_BL8_NCK;
  localparam int PIPE_IDX_W = $clog2(PIPE_LEN + 1);

  typedef enum logic [1:0] {PD_ACTIVE, PD_PENDING, PD_ASLEEP} ddt_pd_e;

  ddt_pkg::ddt_ctrl_s ctrl_r;
  logic [ddt_pkg::EVT_W-1:0] status_r;
  logic [ddt_pkg::EVT_W-1:0] mask_r;
  logic [ddt_pkg::EVT_W-1:0] evt_set;
  logic [31:0] rdata_r;
  logic [31:0] state_word;
  logic [ddt_pkg::CNT_W-1:0] alert_dly_r;
  logic [ddt_pkg::CNT_W-1:0] alert_pw_r;
  logic alert_r;
  logic [ddt_pkg::CNT_W-1:0] rfc_cnt_r;
  logic refresh_busy_r;
  logic [ddt_pkg::CNT_W-1:0] row_cnt_r;
  logic row_busy;
  logic [PIPE_LEN-1:0] wr_pipe_r;
  logic [PIPE_LEN-1:0] wr_pipe_nxt;
  logic [PIPE_IDX_W-1:0] wr_dly;
  logic wr_pending;
  logic ops_busy;
  ddt_pd_e pd_r;
  logic crc_hit;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [ddt_pkg::CNT_W-1:0] rfc_cycles(input ddt_pkg::ddt_fgr_e mode);
    case (mode)
      ddt_pkg::FGR_2X: rfc_cycles = ddt_pkg::CNT_W'(ddt_pkg::RFC2_CYC); // R4
      ddt_pkg::FGR_4X: rfc_cycles = ddt_pkg::CNT_W'(ddt_pkg::RFC4_CYC); // R4
      default: rfc_cycles = ddt_pkg::CNT_W'(ddt_pkg::RFC1_CYC); // R4
    endcase
  endfunction

  function automatic logic hit(input logic [ddt_pkg::ADDR_W-1:0] a,
                               input logic [ddt_pkg::ADDR_W-1:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  // ****************************************
  // Register writes
  // ****************************************
  // Reserved bits are forced to zero so reads never echo junk
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= ddt_pkg::ddt_ctrl_s'(ddt_pkg::CTRL_RESET);
    end else if (wr_i && hit(addr_i, ddt_pkg::CTRL_ADDR)) begin
      ctrl_r <= ddt_pkg::ddt_ctrl_s'(wdata_i);
      ctrl_r.rsvd_hi <= '0;
      ctrl_r.rsvd_lo <= '0;
    end
  end

  // Mask only gates the pin; status bits keep recording events
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_r <= '0;
    end else if (wr_i && hit(addr_i, ddt_pkg::MASK_ADDR)) begin
      mask_r <= wdata_i[ddt_pkg::EVT_W-1:0];
    end
  end

  // Sticky events; a new event beats a same-cycle write-one clear
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_r <= '0;
    end else if (wr_i && hit(addr_i, ddt_pkg::STATUS_ADDR)) begin
      status_r <= (status_r & ~wdata_i[ddt_pkg::EVT_W-1:0]) | evt_set;
    end else begin
      status_r <= status_r | evt_set;
    end
  end

  assign irq_o = |(status_r & mask_r);

  // ****************************************
  // Register reads
  // ****************************************
  always_comb begin
    state_word = '0;
    state_word[ddt_pkg::STATE_RFC_BUSY] = refresh_busy_o;
    state_word[ddt_pkg::STATE_PD_PEND] = (pd_r == PD_PENDING);
    state_word[ddt_pkg::STATE_PD_ASLEEP] = (pd_r == PD_ASLEEP);
    state_word[ddt_pkg::STATE_ALERT] = alert_r;
    state_word[ddt_pkg::STATE_WR_PEND] = wr_pending;
    state_word[ddt_pkg::STATE_DLL_LOCK] = dll_locked_i;
  end

  // Read data stands one cycle, then zero, so stale words never linger
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= '0;
    end else if (!rd_i) begin
      rdata_r <= '0;
    end else begin
      case (addr_i)
        ddt_pkg::CTRL_ADDR: rdata_r <= 32'(ctrl_r);
        ddt_pkg::STATUS_ADDR: rdata_r <= 32'(status_r);
        ddt_pkg::MASK_ADDR: rdata_r <= 32'(mask_r);
        ddt_pkg::STATE_ADDR: rdata_r <= state_word;
        default: rdata_r <= '0;
      endcase
    end
  end

  assign rdata_o = rdata_r;

  // ****************************************
  // CRC error alert
  // ****************************************
  assign crc_hit = crc_err_i && ctrl_r.crc_en;

  // Clock is slower than the latency window, so the first edge is the best fit
  // An error inside the start delay is absorbed, so a pulse never restarts
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alert_dly_r <= '0;
    end else if (crc_hit && !alert_r && alert_dly_r == '0) begin
      alert_dly_r <= ddt_pkg::CNT_W'(ddt_pkg::CRC_ALERT_LAT_CYC); // R1
    end else if (alert_dly_r != '0) begin
      alert_dly_r <= alert_dly_r - 1'b1;
    end
  end

  // Errors during a pulse merge into it rather than stretching it
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alert_r <= 1'b0;
      alert_pw_r <= '0;
    end else if (alert_dly_r == ddt_pkg::CNT_W'(1)) begin
      alert_r <= 1'b1; // R1
      alert_pw_r <= ddt_pkg::CNT_W'(ddt_pkg::CRC_ALERT_PULSE_WIDTH_NCK - 1); // R2
    end else if (alert_pw_r != '0) begin
      alert_pw_r <= alert_pw_r - 1'b1; // R2
    end else begin
      alert_r <= 1'b0;
    end
  end

  assign alert_n_o = ~alert_r;

  // ****************************************
  // Refresh and row operations
  // ****************************************
  // A refresh seen while busy only raises the violation flag, never restarts
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rfc_cnt_r <= '0;
    end else if (cmd_i.ref_cmd && !refresh_busy_o) begin
      rfc_cnt_r <= rfc_cycles(ctrl_r.fgr_mode); // R3 R4
    end else if (rfc_cnt_r != '0) begin
      rfc_cnt_r <= rfc_cnt_r - 1'b1;
    end
  end

  // Flag kept in its own flop so the pin does not hang off a counter compare
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      refresh_busy_r <= 1'b0;
    end else if (cmd_i.ref_cmd && !refresh_busy_r) begin
      refresh_busy_r <= 1'b1; // R3
    end else if (rfc_cnt_r == ddt_pkg::CNT_W'(1)) begin
      refresh_busy_r <= 1'b0; // R4
    end
  end

  assign refresh_busy_o = refresh_busy_r;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      row_cnt_r <= '0;
    end else if (cmd_i.act || cmd_i.pre) begin
      row_cnt_r <= ddt_pkg::CNT_W'(ROW_OP_CYC);
    end else if (row_cnt_r != '0) begin
      row_cnt_r <= row_cnt_r - 1'b1;
    end
  end

  // ****************************************
  // Internal write start
  // ****************************************
  // Recovery rounding is the controller's job; only the start edge is placed here
  // Each write drops a token at its own depth, so back-to-back writes never collide
  always_comb begin
    if (ctrl_r.bc4_fixed) begin
      wr_dly = PIPE_IDX_W'(ctrl_r.write_latency) +
               PIPE_IDX_W'(ddt_pkg::WR_START_BC4_FIXED_NCK); // R5
    end else begin
      wr_dly = PIPE_IDX_W'(ctrl_r.write_latency) +
               PIPE_IDX_W'(ddt_pkg::WR_START_BL8_NCK); // R5 R7
    end
    wr_pipe_nxt = {1'b0, wr_pipe_r[PIPE_LEN-1:1]};
    if (cmd_i.wr && wr_dly != '0) begin
      wr_pipe_nxt[wr_dly - 1'b1] = 1'b1; // R5
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_pipe_r <= '0;
    end else begin
      wr_pipe_r <= wr_pipe_nxt;
    end
  end

  assign wr_start_o = wr_pipe_r[0];

  // ****************************************
  // Power-down entry
  // ****************************************
  assign row_busy = (row_cnt_r != '0);
  assign wr_pending = |wr_pipe_r;
  // Anything still in flight holds off the low-current state
  assign ops_busy = refresh_busy_o || row_busy || wr_pending; // R10

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pd_r <= PD_ACTIVE;
    end else begin
      case (pd_r)
        PD_ACTIVE: begin
          if (!cke_i) begin
            pd_r <= ops_busy ? PD_PENDING : PD_ASLEEP; // R10
          end
        end
        // Cke high aborts a pending entry even with work in flight
        PD_PENDING: begin
          if (cke_i) begin
            pd_r <= PD_ACTIVE;
          end else if (!ops_busy) begin
            pd_r <= PD_ASLEEP; // R10
          end
        end
        PD_ASLEEP: begin
          if (cke_i) begin
            pd_r <= PD_ACTIVE;
          end
        end
        default: pd_r <= PD_ACTIVE;
      endcase
    end
  end

  assign powerdown_o = (pd_r == PD_ASLEEP);

  // ****************************************
  // Events
  // ****************************************
  always_comb begin
    evt_set = '0;
    evt_set[ddt_pkg::EVT_CRC_ERR] = crc_hit;
    evt_set[ddt_pkg::EVT_RFC_VIOL] = refresh_busy_o && (cmd_i.act || cmd_i.ref_cmd); // R3
    evt_set[ddt_pkg::EVT_DLL_VIOL] = !dll_locked_i && (cmd_i.rd || cmd_i.odt_sync); // R9
    // Entry is flagged on the idle cke-low cycle that moves the state to asleep; the bit is sticky anyway
    evt_set[ddt_pkg::EVT_PD_ENTER] = (pd_r != PD_ASLEEP) && !cke_i && !ops_busy;
  end

endmodule // ddt_timing

// ---- dv/ddt_timing_checker.sv ----
// Port-level assertions for the DDR4 timing block
`timescale 1ns/10ps
module ddt_timing_checker (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Watched ports
  input wire ddt_pkg::ddt_cmd_s cmd_i,
  input wire logic cke_i,
  input wire logic crc_err_i,
  input wire logic alert_n_o,
  input wire logic wr_start_o,
  input wire logic refresh_busy_o,
  input wire logic powerdown_o
);
  logic [5:0] since_wr_r;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Saturates so a stale write never aliases a fresh one
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) since_wr_r <= 6'h3f;
    else if (cmd_i.wr) since_wr_r <= 6'h01;
    else if (since_wr_r != 6'h3f) since_wr_r <= since_wr_r + 6'h01;
  end
  property p_alert_lat; $fell(alert_n_o) |-> $past(crc_err_i, 2); endproperty
  a_alert_lat: assert property (p_alert_lat) else $error("alert without error");
  property p_alert_pw; $fell(alert_n_o) |-> (!alert_n_o)[*8] ##1 alert_n_o; endproperty
  a_alert_pw: assert property (p_alert_pw) else $error("alert width wrong");
  property p_wr_start; wr_start_o |-> since_wr_r >= 6'h02 && since_wr_r <= 6'h23; endproperty
  a_wr_start: assert property (p_wr_start) else $error("write start misplaced");
  property p_ref_cause; $rose(refresh_busy_o) |-> $past(cmd_i.ref_cmd); endproperty
  a_ref_cause: assert property (p_ref_cause) else $error("busy without refresh");
  property p_ref_len; $rose(refresh_busy_o) |-> refresh_busy_o[*5] ##[1:7] !refresh_busy_o;
  endproperty
  a_ref_len: assert property (p_ref_len) else $error("refresh period wrong");
  property p_pd_idle; powerdown_o |-> !refresh_busy_o; endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("asleep during refresh");
  property p_pd_entry; $rose(powerdown_o) |-> !$past(cke_i); endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("sleep without cke low");
  property p_pd_exit; powerdown_o && cke_i |=> !powerdown_o; endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("sleep kept after cke");
endmodule // ddt_timing_checker

bind ddt_timing ddt_timing_checker u_chk (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .cmd_i(cmd_i), .cke_i(cke_i),
  .crc_err_i(crc_err_i), .alert_n_o(alert_n_o), .wr_start_o(wr_start_o),
  .refresh_busy_o(refresh_busy_o), .powerdown_o(powerdown_o)
);

// ---- dv/ddt_ctrl_model.sv ----
// Memory controller model facing the DDR4 timing block
`timescale 1ns/10ps
module ddt_ctrl_model (
  // Clock and feedback
  input wire logic clock_i,
  input wire logic refresh_busy_i,
  // Command side
  output ddt_pkg::ddt_cmd_s cmd_o,
  output logic cke_o,
  output logic dll_locked_o,
  output logic crc_err_o
);
  task automatic idle();
    cmd_o <= '0;
    cke_o <= 1'b1;
    dll_locked_o <= 1'b1;
    crc_err_o <= 1'b0;
  endtask
  task automatic send(input ddt_pkg::ddt_cmd_s c);
    @(posedge clock_i);
    cmd_o <= c;
    @(posedge clock_i);
    cmd_o <= '0;
  endtask
  task automatic crc_hit(input int n);
    @(posedge clock_i);
    crc_err_o <= 1'b1;
    repeat (n) @(posedge clock_i);
    crc_err_o <= 1'b0;
  endtask
  task automatic cke_set(input logic v);
    @(posedge clock_i);
    cke_o <= v;
  endtask
  // Cleared only when a test means to break the lock rule
  task automatic dll_set(input logic v);
    @(posedge clock_i);
    dll_locked_o <= v;
  endtask
  // No further command until the period is over
  task automatic refresh(input int n, output int busy);
    busy = 0;
    send(6'h08);
    for (int i = 1; i <= n + 2; i++) begin
      #1;
      if (refresh_busy_i === 1'b1) busy++;
      @(posedge clock_i);
    end
  endtask
  // Recovery in ns rounded up to whole clocks; CRC with mask takes the longer figure
  task automatic pd_after_write(input int wl, input int wr_ns, input int wr_crc_dm_ns,
                                input bit crc_dm);
    int rec_ns;
    rec_ns = crc_dm ? wr_crc_dm_ns : wr_ns;
    send(6'h04);
    repeat (wl + 4 + (rec_ns * ddt_pkg::PS_PER_NS + ddt_pkg::CLK_PERIOD_PS - 1) /
            ddt_pkg::CLK_PERIOD_PS) @(posedge clock_i);
    cke_o <= 1'b0;
  endtask
endmodule // ddt_ctrl_model

// ---- dv/ddt_timing_tb.sv ----
// Self-checking bench of the DDR4 timing block
`timescale 1ns/10ps
module ddt_timing_tb;
  logic clock_i;
  logic arst_n_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [31:0] rdata_o;
  ddt_pkg::ddt_cmd_s cmd_i;
  logic cke_i, dll_locked_i, crc_err_i, alert_n_o, wr_start_o;
  logic refresh_busy_o, powerdown_o, irq_o;
  int err_total = 0;
  int checks_done = 0;
  always #12.5 clock_i = ~clock_i;
  ddt_timing #(.WL_MAX(31), .ROW_OP_CYC(2)) DUT (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmd_i(cmd_i), .cke_i(cke_i),
    .dll_locked_i(dll_locked_i), .crc_err_i(crc_err_i), .alert_n_o(alert_n_o),
    .wr_start_o(wr_start_o), .refresh_busy_o(refresh_busy_o),
    .powerdown_o(powerdown_o), .irq_o(irq_o));
  ddt_ctrl_model ctl (
    .clock_i(clock_i), .refresh_busy_i(refresh_busy_o), .cmd_o(cmd_i), .cke_o(cke_i),
    .dll_locked_o(dll_locked_i), .crc_err_o(crc_err_i));
  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(n, e, rdata_o);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rd(8'h00, 32'h900, "ctrl reset");
    rd(8'h10, 32'h0, "unmapped");
    wr(8'h0c, 32'hff);
    rd(8'h0c, 32'h20, "state read only");
  endtask
  task automatic t_alert();
    int first;
    int lows;
    wr(8'h00, 32'h908);
    // Second pass holds the error two cycles: the extra one falls in the start delay and is absorbed
    for (int k = 1; k <= 2; k++) begin
      first = 0;
      lows = 0;
      ctl.crc_hit(k);
      for (int i = 1; i <= 12; i++) begin
        #1;
        if (alert_n_o === 1'b0 && first == 0) first = i;
        if (alert_n_o === 1'b0) lows++;
        @(posedge clock_i);
      end
      chk("alert start", 3 - k, first);
      chk("alert width", 8, lows);
    end
    rd(8'h04, 32'h1, "crc status");
    chk("irq masked", 0, irq_o);
    wr(8'h08, 32'h1);
    @(posedge clock_i);
    #1 chk("irq set", 1, irq_o);
    wr(8'h04, 32'h1);
    @(posedge clock_i);
    #1 chk("irq clear", 0, irq_o);
  endtask
  task automatic t_refresh();
    int ns[3] = '{260, 160, 110};
    int busy;
    for (int m = 0; m < 3; m++) begin
      wr(8'h00, 32'h900 | m);
      ctl.refresh((ns[m] + 24) / 25, busy);
      chk("refresh busy", (ns[m] + 24) / 25, busy);
    end
  endtask
  task automatic t_wstart();
    int at;
    int n;
    for (int b = 0; b < 2; b++) begin
      wr(8'h00, 32'h900 | (b << 2));
      ctl.send(6'h04);
      at = 0;
      n = 0;
      for (int i = 1; i <= 40; i++) begin
        #1;
        if (wr_start_o === 1'b1) at = i;
        if (wr_start_o === 1'b1) n++;
        @(posedge clock_i);
      end
      chk("write start", b ? 11 : 13, at);
      chk("write pulses", 1, n);
    end
  endtask
  task automatic t_pd();
    // CRC and mask both on, so the model takes the longer recovery
    wr(8'h00, 32'h918);
    ctl.send(6'h08);
    ctl.cke_set(1'b0);
    repeat (3) @(posedge clock_i);
    #1 chk("pd while busy", 0, powerdown_o);
    repeat (10) @(posedge clock_i);
    #1 chk("pd after busy", 1, powerdown_o);
    rd(8'h04, 32'h8, "pd status");
    ctl.cke_set(1'b1);
    @(posedge clock_i);
    #1 chk("pd exit", 0, powerdown_o);
    ctl.pd_after_write(9, 15, 40, 1'b1);
    @(posedge clock_i);
    #1 chk("pd idle", 1, powerdown_o);
    ctl.cke_set(1'b1);
    wr(8'h04, 32'hf);
    ctl.dll_set(1'b0);
    ctl.send(6'h02);
    ctl.dll_set(1'b1);
    rd(8'h04, 32'h4, "dll status");
  endtask
  task automatic t_viol();
    wr(8'h04, 32'hf);
    ctl.send(6'h08);
    ctl.send(6'h20);
    rd(8'h04, 32'h2, "refresh violation");
    repeat (12) @(posedge clock_i);
    ctl.send(6'h10);
    ctl.cke_set(1'b0);
    @(posedge clock_i);
    #1 chk("pd behind row op", 0, powerdown_o);
    @(posedge clock_i);
    #1 chk("pd after row op", 1, powerdown_o);
    ctl.cke_set(1'b1);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clock_i = 1'b0;
    arst_n_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ctl.idle();
    repeat (3) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_alert();
    t_refresh();
    t_wstart();
    t_pd();
    t_viol();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge clock_i);
    err_total++;
    end_sim();
  end
endmodule // ddt_timing_tb
